// ==== design/rtdc_direction_ctrl.sv ====
// Purpose: Chooses line driver and receiver enables for an RS-485 port,
//   tracks FIFO fill levels, raises the receive trigger request and
//   decodes the I/O windows of ports 0 and 1, or one four-port window on port_hit[0] when quad_variant is set.
// Assumes: The serial core reports FIFO pushes and pops as pulses.
module rtdc_direction_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mode_load,
  input wire logic [7:0] mode_code,
  input wire logic dtr_n,
  input wire logic tx_holding_space_indication,
  input wire logic fifo_enable,
  input wire logic [rtdc_pkg::CNT_W-1:0] rx_trigger,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic tx_pop,
  input wire logic quad_variant,
  input wire logic [rtdc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [rtdc_pkg::ADDR_W-1:0] base0,
  input wire logic [rtdc_pkg::ADDR_W-1:0] base1,
  input wire logic [1:0] port_irq_req,
  output logic drv_en,
  output logic rcv_en,
  output logic [1:0] mode_sel,
  output logic fifo_on,
  output logic [rtdc_pkg::CNT_W-1:0] rx_level,
  output logic [rtdc_pkg::CNT_W-1:0] tx_level,
  output logic rx_trigger_req,
  output logic [1:0] port_hit,
  output logic shared_irq
);
  typedef logic [rtdc_pkg::ADDR_W-1:0] rtdc_addr_t;

  typedef enum logic [1:0] {
    ST_FOUR, ST_DTR_ECHO, ST_DTR_NOECHO, ST_AUTO
  } rtdc_mode_t;

  typedef struct packed {
    rtdc_mode_t mode;
    logic drv;
    logic rcv;
    logic fifo;
    logic [rtdc_pkg::CNT_W-1:0] rxc;
    logic [rtdc_pkg::CNT_W-1:0] txc;
    logic trig;
    logic [1:0] hit;
    logic irq;
  } rtdc_state_t;

  rtdc_state_t st_ff;
  rtdc_state_t nxt_st;
  rtdc_mode_t mode_now;
  logic dtr_asserted;
  rtdc_addr_t off0;
  rtdc_addr_t off1;

  always_comb begin
    nxt_st = st_ff;
    mode_now = st_ff.mode;
    if (mode_load) begin
      unique case (mode_code)
        rtdc_pkg::MODE_DTR_ECHO: mode_now = ST_DTR_ECHO;
        rtdc_pkg::MODE_DTR_NOECHO: mode_now = ST_DTR_NOECHO;
        rtdc_pkg::MODE_AUTO: mode_now = ST_AUTO;
        default: mode_now = ST_FOUR;
      endcase
    end
    nxt_st.mode = mode_now;
    dtr_asserted = !dtr_n;
    unique case (mode_now)
      ST_FOUR: begin
        nxt_st.drv = 1'b1;
        nxt_st.rcv = 1'b1;
      end
      ST_DTR_ECHO: begin
        nxt_st.drv = !dtr_asserted;
        nxt_st.rcv = 1'b1;
      end
      ST_DTR_NOECHO: begin
        nxt_st.drv = !dtr_asserted;
        nxt_st.rcv = dtr_asserted;
      end
      ST_AUTO: begin
        nxt_st.drv = tx_holding_space_indication;
        nxt_st.rcv = !tx_holding_space_indication;
      end
    endcase
    nxt_st.fifo = fifo_enable;
    if (!fifo_enable) begin
      nxt_st.rxc = rtdc_pkg::CNT_ZERO;
      nxt_st.txc = rtdc_pkg::CNT_ZERO;
    end else begin
      if (rx_push && !rx_pop && st_ff.rxc != rtdc_pkg::CNT_FULL)
        nxt_st.rxc = st_ff.rxc + rtdc_pkg::CNT_ONE;
      else if (rx_pop && !rx_push && st_ff.rxc != rtdc_pkg::CNT_ZERO)
        nxt_st.rxc = st_ff.rxc - rtdc_pkg::CNT_ONE;
      if (tx_push && !tx_pop && st_ff.txc != rtdc_pkg::CNT_FULL)
        nxt_st.txc = st_ff.txc + rtdc_pkg::CNT_ONE;
      else if (tx_pop && !tx_push && st_ff.txc != rtdc_pkg::CNT_ZERO)
        nxt_st.txc = st_ff.txc - rtdc_pkg::CNT_ONE;
    end
    nxt_st.trig = fifo_enable && (rx_trigger != rtdc_pkg::CNT_ZERO) &&
                  (nxt_st.rxc >= rx_trigger);
    off0 = bus_addr - base0;
    off1 = bus_addr - base1;
    if (quad_variant) begin
      nxt_st.hit[0] = (bus_addr >= base0) &&
                      (off0 < rtdc_addr_t'(rtdc_pkg::QUAD_WIN_BYTES));
      nxt_st.hit[1] = 1'b0;
    end else begin
      nxt_st.hit[0] = (bus_addr >= base0) &&
                      (off0 < rtdc_addr_t'(rtdc_pkg::PORT_WIN_BYTES));
      nxt_st.hit[1] = (bus_addr >= base1) &&
                      (off1 < rtdc_addr_t'(rtdc_pkg::PORT_WIN_BYTES));
    end
    nxt_st.irq = |port_irq_req;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.mode <= ST_FOUR;
      st_ff.drv <= 1'b1;
      st_ff.rcv <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign drv_en = st_ff.drv;
  assign rcv_en = st_ff.rcv;
  assign mode_sel = st_ff.mode;
  assign fifo_on = st_ff.fifo;
  assign rx_level = st_ff.rxc;
  assign tx_level = st_ff.txc;
  assign rx_trigger_req = st_ff.trig;
  assign port_hit = st_ff.hit;
  assign shared_irq = st_ff.irq;

  property p_four_wire;
    @(posedge clk) disable iff (!resetn)
    (mode_sel == rtdc_pkg::SEL_FOUR) |-> (drv_en && rcv_en);
  endproperty
  a_four_wire: assert property (p_four_wire)
    else $error("Four-wire mode disabled a transceiver side.");

  property p_default;
    @(posedge clk) $rose(resetn) |-> (mode_sel == rtdc_pkg::SEL_FOUR);
  endproperty
  a_default: assert property (p_default)
    else $error("Mode after reset is not four-wire.");

  property p_dtr_drv;
    @(posedge clk) disable iff (!resetn)
    (!mode_load && (mode_sel == rtdc_pkg::SEL_DTR_ECHO ||
      mode_sel == rtdc_pkg::SEL_DTR_NOECHO)) |=> (drv_en == $past(dtr_n));
  endproperty
  a_dtr_drv: assert property (p_dtr_drv)
    else $error("Driver does not follow terminal-ready.");

  property p_echo_rcv;
    @(posedge clk) disable iff (!resetn)
    (mode_sel == rtdc_pkg::SEL_DTR_ECHO) |-> rcv_en;
  endproperty
  a_echo_rcv: assert property (p_echo_rcv)
    else $error("Echo mode disabled the receiver.");

  property p_noecho_rcv;
    @(posedge clk) disable iff (!resetn)
    (mode_sel == rtdc_pkg::SEL_DTR_NOECHO) |-> (rcv_en != drv_en);
  endproperty
  a_noecho_rcv: assert property (p_noecho_rcv)
    else $error("Non-echo mode let receiver and driver overlap.");

  property p_auto_drv;
    @(posedge clk) disable iff (!resetn)
    (!mode_load && mode_sel == rtdc_pkg::SEL_AUTO) |=>
      (drv_en == $past(tx_holding_space_indication));
  endproperty
  a_auto_drv: assert property (p_auto_drv)
    else $error("Auto mode driver does not follow transmit-ready.");

  property p_auto_rcv;
    @(posedge clk) disable iff (!resetn)
    (mode_sel == rtdc_pkg::SEL_AUTO) |-> (rcv_en == !drv_en);
  endproperty
  a_auto_rcv: assert property (p_auto_rcv)
    else $error("Auto mode receiver overlaps the driver.");

  property p_load;
    @(posedge clk) disable iff (!resetn)
    (mode_load && mode_code == rtdc_pkg::MODE_AUTO) |=>
      (mode_sel == rtdc_pkg::SEL_AUTO);
  endproperty
  a_load: assert property (p_load)
    else $error("Mode code 131 did not select auto mode.");

  property p_fifo_off;
    @(posedge clk) disable iff (!resetn)
    !fifo_enable |=> (rx_level == '0 && tx_level == '0 && !rx_trigger_req);
  endproperty
  a_fifo_off: assert property (p_fifo_off)
    else $error("FIFOs hold data while disabled.");

  property p_trig;
    @(posedge clk) disable iff (!resetn)
    (fifo_on && rx_trigger != '0 && rx_level >= rx_trigger &&
     !rx_pop && fifo_enable) |=> rx_trigger_req;
  endproperty
  a_trig: assert property (p_trig)
    else $error("Receive trigger level reached without request.");

  property p_irq;
    @(posedge clk) disable iff (!resetn)
    (|port_irq_req) |=> shared_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("Shared request line missed a port request.");
endmodule : rtdc_direction_ctrl

// ==== design/rtdc_pkg.sv ====
// Purpose: Constants for the line transceiver direction control block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Mode codes are the values software writes to select a mode.
package rtdc_pkg;
  localparam logic [7:0] MODE_FOUR_WIRE = 8'h80;
  localparam logic [7:0] MODE_DTR_ECHO = 8'h81;
  localparam logic [7:0] MODE_DTR_NOECHO = 8'h82;
  localparam logic [7:0] MODE_AUTO = 8'h83;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int PORT_WIN_BYTES = 8;
  localparam int PORT_COUNT_QUAD = 4;
  localparam int QUAD_WIN_BYTES = PORT_WIN_BYTES * PORT_COUNT_QUAD;
  localparam int ADDR_W = 16;
  localparam logic [1:0] SEL_FOUR = 2'h0;
  localparam logic [1:0] SEL_DTR_ECHO = 2'h1;
  localparam logic [1:0] SEL_DTR_NOECHO = 2'h2;
  localparam logic [1:0] SEL_AUTO = 2'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
endpackage : rtdc_pkg

// ==== sim/rtdc_direction_ctrl_test.sv ====
// Purpose: Self-checking bench for the direction control block.
// Assumes: Inputs change on the falling edge.
// Notes: Outputs are checked one or more cycles after each change.
module rtdc_direction_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, mode_load = 0, dtr_n = 1, txh = 0;
  logic fifo_enable = 0, rx_push = 0, rx_pop = 0, tx_push = 0;
  logic tx_pop = 0, quad_variant = 0, drv_en, rcv_en, fifo_on;
  logic rx_trigger_req, shared_irq, heard;
  logic [7:0] mode_code = 8'h00;
  logic [4:0] rx_trigger = 5'h00, rx_level, tx_level;
  logic [15:0] bus_addr = 16'h0000, base0 = 16'h0100, base1 = 16'h02F8;
  logic [1:0] port_irq_req = 2'h0, mode_sel, port_hit;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  rtdc_direction_ctrl u_dut (.clk(clk), .resetn(resetn),
    .mode_load(mode_load), .mode_code(mode_code), .dtr_n(dtr_n),
    .tx_holding_space_indication(txh), .fifo_enable(fifo_enable),
    .rx_trigger(rx_trigger), .rx_push(rx_push), .rx_pop(rx_pop),
    .tx_push(tx_push), .tx_pop(tx_pop), .quad_variant(quad_variant),
    .bus_addr(bus_addr), .base0(base0), .base1(base1),
    .port_irq_req(port_irq_req), .drv_en(drv_en), .rcv_en(rcv_en),
    .mode_sel(mode_sel), .fifo_on(fifo_on), .rx_level(rx_level),
    .tx_level(tx_level), .rx_trigger_req(rx_trigger_req),
    .port_hit(port_hit), .shared_irq(shared_irq));
  rtdc_line_dev u_peer (.clk(clk), .drv_en(drv_en), .rcv_en(rcv_en),
    .heard(heard));
  initial begin
    forever #20 clk = ~clk;
  end
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task load(input logic [7:0] c);
    mode_code = c;
    mode_load = 1;
    step(1);
    mode_load = 0;
    step(2);
  endtask : load
  // Walks every mode code against every terminal-ready and ready level.
  task t_modes;
    logic d, r;
    fifo_enable = 1;
    for (int i = 0; i < 4; i++) begin
      load(8'h80 + i[7:0]);
      chk(mode_sel, i[15:0], "mode select");
      for (int k = 0; k < 4; k++) begin
        dtr_n = k[0];
        txh = k[1];
        step(2);
        d = (i == 0) | ((i == 1 | i == 2) & dtr_n) | ((i == 3) & txh);
        r = (i == 0) | (i == 1) | ((i == 2) & !dtr_n) | ((i == 3) & !txh);
        chk(drv_en, d, "driver enable");
        chk(rcv_en, r, "receiver enable");
        chk(heard, r & !d, "peer reception");
      end
    end
    load(8'h84);
    chk(mode_sel, 16'h0000, "unknown code");
  endtask : t_modes
  // The host frames a block with terminal-ready and hears its own echo.
  task t_echo_send;
    load(8'h81);
    dtr_n = 0;
    step(2);
    chk(drv_en, 0, "echo idle driver");
    dtr_n = 1;
    tx_push = 1;
    step(4);
    tx_push = 0;
    chk(tx_level, 16'h0004, "tx block");
    chk({drv_en, rcv_en}, 16'h0003, "echo sending");
    tx_pop = 1;
    step(4);
    tx_pop = 0;
    chk(tx_level, 16'h0000, "tx drained");
    dtr_n = 0;
    step(2);
    chk({drv_en, rcv_en}, 16'h0001, "echo done");
  endtask : t_echo_send
  task t_fifo;
    fifo_enable = 1;
    load(8'h83);
    rx_trigger = 5'h02;
    rx_push = 1;
    step(1);
    rx_push = 0;
    step(2);
    chk(rx_trigger_req, 0, "early trigger");
    rx_push = 1;
    tx_push = 1;
    step(17);
    rx_push = 0;
    tx_push = 0;
    step(2);
    chk(rx_trigger_req, 1, "trigger");
    chk(tx_level, 16'h0010, "tx saturate");
    chk(fifo_on, 1, "fifo on");
    chk(rx_level, 16'h0010, "rx saturate");
    rx_pop = 1;
    tx_pop = 1;
    step(1);
    rx_pop = 0;
    tx_pop = 0;
    chk(rx_level, 16'h000F, "rx pop");
    chk(tx_level, 16'h000F, "tx pop");
    rx_push = 1;
    rx_pop = 1;
    step(1);
    rx_push = 0;
    rx_pop = 0;
    chk(rx_level, 16'h000F, "push with pop");
    rx_trigger = 5'h10;
    step(2);
    chk(rx_trigger_req, 0, "below trigger");
    load(8'h80);
    fifo_enable = 0;
    step(2);
    chk(rx_level, 16'h0000, "rx cleared");
    chk(tx_level, 16'h0000, "tx cleared");
    chk(fifo_on, 0, "fifo off");
    fifo_enable = 1;
    rx_trigger = 5'h02;
  endtask : t_fifo
  task t_addr;
    bus_addr = base0 + 16'h0007;
    port_irq_req = 2'h2;
    step(2);
    chk(port_hit, 16'h0001, "port0 last byte");
    chk(shared_irq, 1, "shared request");
    bus_addr = base0 + 16'h0008;
    step(2);
    chk(port_hit, 16'h0000, "port0 past end");
    quad_variant = 1;
    bus_addr = base0 + 16'h001F;
    step(2);
    chk(port_hit, 16'h0001, "quad window");
    bus_addr = base0 + 16'h0020;
    step(2);
    chk(port_hit, 16'h0000, "quad past end");
    quad_variant = 0;
    bus_addr = base1 + 16'h0003;
    step(2);
    chk(port_hit, 16'h0002, "port1");
    bus_addr = base0 - 16'h0001;
    port_irq_req = 2'h0;
    step(2);
    chk(port_hit, 16'h0000, "below base");
    chk(shared_irq, 0, "request idle");
  endtask : t_addr
  // A mid-run reset stands for reopening the port.
  task t_reopen;
    load(8'h82);
    resetn = 0;
    step(2);
    resetn = 1;
    step(1);
    chk(mode_sel, 16'h0000, "reopen default");
    chk({drv_en, rcv_en}, 16'h0003, "reopen enables");
    load(8'h82);
    chk(mode_sel, 16'h0002, "stored mode");
  endtask : t_reopen
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    step(3);
    resetn = 1;
    step(1);
    chk(mode_sel, 16'h0000, "reset mode");
    chk({drv_en, rcv_en}, 16'h0003, "reset enables");
    t_modes();
    t_echo_send();
    t_fifo();
    t_addr();
    t_reopen();
    wrap_up();
  end
endmodule : rtdc_direction_ctrl_test

// ==== sim/rtdc_line_dev.sv ====
// Purpose: Half-duplex far node on the two-wire line.
// Assumes: The peer talks only in the cycle after one with the local driver off.
// Notes: heard shows whether its traffic reaches the local receiver.
module rtdc_line_dev (
  input wire logic clk,
  input wire logic drv_en,
  input wire logic rcv_en,
  output logic heard
);
  timeunit 1ns;
  timeprecision 1ps;
  logic far_talk;
  // The peer waits one cycle after the line is freed before driving it.
  always_ff @(posedge clk) begin
    far_talk <= !drv_en;
  end
  assign heard = rcv_en & far_talk;
endmodule : rtdc_line_dev
